// >>> rtc_twi_pkg.sv
// constants and types shared by the serial slave and its watchdog
// Notes on behaviour
// R1: one bit per SCL pulse; SDA moving while SCL high is control.
// R2: idle bus rests high; SDA falling while SCL high is START.
// R3: SDA rising while SCL high is STOP, ending every transfer.
// R4: master starts a new transfer only while the bus is idle.
// R5: any number of bytes; eight bits each, then one acknowledge clock.
// R6: addressed slave receiver acknowledges every byte, addresses included.
// R7: master receiver acknowledges every byte shifted out except the last one.
// R8: acknowledger holds SDA low through the acknowledge pulse high phase.
// R9: unacknowledged byte ends a read; slave releases SDA so master can STOP.
// R10: first byte after START is the slave address; respond only on a match.
// R11: slave only; SCL is input only, SDA is open-drain bidirectional.
// R12: address byte A3h selects read, A2h selects write.
// R13: byte after write address is word address; low 4 bits pick register.
// R14: time counters are frozen while an access is in progress.
// R15: interface active over 1 s after valid address is cleared by the device.
// R16: watchdog fires no sooner than 1 s, no later than 2 s after address.
// R17: each watchdog expiry drops exactly one second increment.
// R18: register pointer advances by one after every data byte written or read.
// R19: on watchdog clear, release SDA, drop the transfer, wait for START.
package rtc_twi_pkg;

	localparam logic [7:0] ADDR_WR   = 8'hA2;
	localparam logic [7:0] ADDR_RD   = 8'hA3;
	localparam int         PTR_W     = 4;
	localparam int         BYTE_W    = 8;
	localparam logic [2:0] BIT_LAST  = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;

	localparam logic [1:0] IDX_ADDR  = 2'h0;
	localparam logic [1:0] IDX_WORD  = 2'h1;
	localparam logic [1:0] IDX_DATA  = 2'h2;

	// watchdog window, in seconds
	localparam int         WDOG_MIN_S = 1;
	localparam int         WDOG_MAX_S = 2;
	// second boundaries seen after the address: the second one lands in [1,2] s
	localparam logic [1:0] WDOG_TICKS = 2'(WDOG_MIN_S + 1);
	localparam int         DEF_OSC_HZ = 32768;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACKW = 3'b010,
		ST_ACK  = 3'b011,
		ST_TX   = 3'b100,
		ST_MACK = 3'b101,
		ST_WAIT = 3'b110
	} twi_state_t;

endpackage

// >>> rtc_twi_wdog.sv
// oscillator-domain second prescaler, counter freeze and interface watchdog
`timescale 1ns/1ps
module rtc_twi_wdog #(
	parameter int OSC_HZ = rtc_twi_pkg::DEF_OSC_HZ
) (
	input  wire logic osc_clk,
	input  wire logic reset,
	input  wire logic access,
	output logic      expire_tgl,
	output logic      sec_tick,
	output logic      time_frozen
);
	import rtc_twi_pkg::*;

	localparam int         CYC_PER_SEC = OSC_HZ * WDOG_MIN_S;
	localparam int         PRE_W       = $clog2(CYC_PER_SEC);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_SEC - 1);
	localparam logic [PRE_W-1:0] PRE_ONE  = PRE_W'(1);

	logic             rst_meta_ff;
	logic             rst_ff;
	logic             acc_meta_ff;
	logic             acc_sync_ff;
	logic [PRE_W-1:0] pre_ff;
	logic [1:0]       wd_cnt_ff;
	logic             fired_ff;
	logic             pend_ff;
	logic             tgl_ff;
	logic             tick_ff;
	logic             frozen_ff;

	wire sec_edge = (pre_ff == PRE_LAST);
	// after firing the access level is still high until the other domain
	// clears it; fired_ff keeps counting alive and stops a second expiry
	wire frozen   = acc_sync_ff & ~fired_ff; // R14
	wire fire     = frozen & sec_edge & (wd_cnt_ff == WDOG_TICKS - 2'h1); // R16
	wire nxt_pend = frozen ? (pend_ff | (sec_edge & ~fire)) // R17
	                       : (pend_ff & sec_edge);
	wire nxt_tick = ~frozen & (sec_edge | pend_ff);
	wire [1:0] nxt_wd_cnt = ~frozen ? 2'h0
	                      : (sec_edge ? wd_cnt_ff + 2'h1 : wd_cnt_ff);
	wire nxt_fired = acc_sync_ff & (fired_ff | fire); // R15

	// reset and access level arrive from the system clock domain
	always_ff @(posedge osc_clk) begin
		rst_meta_ff <= reset;
		rst_ff      <= rst_meta_ff;
		acc_meta_ff <= access;
		acc_sync_ff <= acc_meta_ff;
	end

	always_ff @(posedge osc_clk) begin
		if (rst_ff) begin
			pre_ff    <= '0;
			wd_cnt_ff <= 2'h0;
			fired_ff  <= 1'b0;
			pend_ff   <= 1'b0;
			tgl_ff    <= 1'b0;
			tick_ff   <= 1'b0;
			frozen_ff <= 1'b0;
		end else begin
			pre_ff    <= sec_edge ? '0 : pre_ff + PRE_ONE;
			wd_cnt_ff <= nxt_wd_cnt;
			fired_ff  <= nxt_fired;
			pend_ff   <= nxt_pend;
			tgl_ff    <= tgl_ff ^ fire;
			tick_ff   <= nxt_tick;
			frozen_ff <= frozen;
		end
	end

	assign expire_tgl  = tgl_ff;
	assign sec_tick    = tick_ff;
	assign time_frozen = frozen_ff;

endmodule

// >>> rtc_twi_slave.sv
// two-wire serial slave of the clock: framing, addressing, register pointer
`timescale 1ns/1ps
module rtc_twi_slave #(
	parameter int OSC_HZ = rtc_twi_pkg::DEF_OSC_HZ
) (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        osc_clk,
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe,
	output logic [rtc_twi_pkg::PTR_W-1:0]    rd_addr,
	input  wire logic [rtc_twi_pkg::BYTE_W-1:0] rd_data,
	output logic                             rd_en,
	output logic [rtc_twi_pkg::PTR_W-1:0]    wr_addr,
	output logic [rtc_twi_pkg::BYTE_W-1:0]   wr_data,
	output logic                             wr_en,
	output logic                             access,
	output logic                             sec_tick,
	output logic                             time_frozen
);
	import rtc_twi_pkg::*;

	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [2:0]       CNT_ONE = 3'h1;

	// pin synchronisers plus one history stage for edge detection
	logic scl_meta_ff;
	logic scl_sync_ff;
	logic scl_prev_ff;
	logic sda_meta_ff;
	logic sda_sync_ff;
	logic sda_prev_ff;
	logic exp_meta_ff;
	logic exp_sync_ff;
	logic exp_prev_ff;

	twi_state_t         state_ff;
	logic [2:0]         cnt_ff;
	logic [1:0]         idx_ff;
	logic               rw_ff;
	logic               access_ff;
	logic [BYTE_W-1:0]  shift_ff;
	logic [BYTE_W-1:0]  tx_ff;
	logic [PTR_W-1:0]   ptr_ff;
	logic               mack_ff;
	logic               sda_oe_ff;
	logic               wr_en_ff;
	logic               rd_en_ff;
	logic [PTR_W-1:0]   wr_addr_ff;
	logic [BYTE_W-1:0]  wr_data_ff;

	twi_state_t         nxt_state;
	logic [2:0]         nxt_cnt;
	logic [1:0]         nxt_idx;
	logic               nxt_rw;
	logic               nxt_access;
	logic [BYTE_W-1:0]  nxt_shift;
	logic [BYTE_W-1:0]  nxt_tx;
	logic [PTR_W-1:0]   nxt_ptr;
	logic               nxt_mack;
	logic               nxt_sda_oe;
	logic               nxt_wr_en;
	logic               nxt_rd_en;
	logic [PTR_W-1:0]   nxt_wr_addr;
	logic [BYTE_W-1:0]  nxt_wr_data;

	logic               expire_tgl;

	// bus events, all from the second and third stages only
	wire scl_rise   = scl_sync_ff & ~scl_prev_ff; // R1
	wire scl_fall   = ~scl_sync_ff & scl_prev_ff;
	wire scl_high   = scl_sync_ff & scl_prev_ff;
	wire start_seen = scl_high & sda_prev_ff & ~sda_sync_ff; // R2
	wire stop_seen  = scl_high & ~sda_prev_ff & sda_sync_ff; // R3
	wire wd_expire  = exp_sync_ff ^ exp_prev_ff;

	// byte completed on this rising edge
	wire [BYTE_W-1:0] rx_byte  = {shift_ff[BYTE_W-2:0], sda_sync_ff};
	wire              byte_end = (cnt_ff == BIT_LAST);
	wire              hit_wr   = (rx_byte == ADDR_WR); // R12
	wire              hit_rd   = (rx_byte == ADDR_RD); // R12
	wire              tx_last  = (cnt_ff == BIT_LAST);
	// open drain: a 1 bit is sent by releasing the line
	wire              load_oe  = ~rd_data[BYTE_W-1];
	wire              next_oe  = ~tx_ff[BYTE_W-2];

	always_ff @(posedge clk) begin
		scl_meta_ff <= scl_in;
		scl_sync_ff <= scl_meta_ff;
		scl_prev_ff <= scl_sync_ff;
		sda_meta_ff <= sda_in;
		sda_sync_ff <= sda_meta_ff;
		sda_prev_ff <= sda_sync_ff;
		exp_meta_ff <= expire_tgl;
		exp_sync_ff <= exp_meta_ff;
		exp_prev_ff <= exp_sync_ff;
	end

	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_idx     = idx_ff;
		nxt_rw      = rw_ff;
		nxt_access  = access_ff;
		nxt_shift   = shift_ff;
		nxt_tx      = tx_ff;
		nxt_ptr     = ptr_ff;
		nxt_mack    = mack_ff;
		nxt_sda_oe  = sda_oe_ff;
		nxt_wr_en   = 1'b0;
		nxt_rd_en   = 1'b0;
		nxt_wr_addr = wr_addr_ff;
		nxt_wr_data = wr_data_ff;
		if (wd_expire) begin
			// hung master: let go of the line and wait for a fresh START
			nxt_state  = ST_IDLE; // R15 R19
			nxt_access = 1'b0; // R19
			nxt_sda_oe = 1'b0; // R19
		end else if (start_seen) begin
			// repeated START is legal; the pointer survives it
			nxt_state  = ST_RX; // R10
			nxt_cnt    = BIT_FIRST;
			nxt_idx    = IDX_ADDR; // R10
			nxt_access = 1'b0;
			nxt_sda_oe = 1'b0;
		end else if (stop_seen) begin
			nxt_state  = ST_IDLE; // R3
			nxt_access = 1'b0; // R14
			nxt_sda_oe = 1'b0;
		end else begin
			case (state_ff)
			ST_RX: begin
				if (scl_rise) begin
					nxt_shift = rx_byte; // R1
					nxt_cnt   = cnt_ff + CNT_ONE;
					if (byte_end) begin // R5
						nxt_state = ST_ACKW; // R6
						if (idx_ff == IDX_ADDR) begin
							if (hit_wr || hit_rd) begin // R10
								nxt_rw     = hit_rd; // R12
								nxt_access = 1'b1; // R14
								nxt_idx    = IDX_WORD;
							end else begin
								nxt_state = ST_WAIT; // R10
							end
						end else if (idx_ff == IDX_WORD) begin
							nxt_ptr = rx_byte[PTR_W-1:0]; // R13
							nxt_idx = IDX_DATA;
						end else begin
							nxt_wr_en   = 1'b1;
							nxt_wr_addr = ptr_ff;
							nxt_wr_data = rx_byte;
							nxt_ptr     = ptr_ff + PTR_ONE; // R18
						end
					end
				end
			end
			ST_ACKW: begin
				if (scl_fall) begin
					nxt_sda_oe = 1'b1; // R8
					nxt_state  = ST_ACK;
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					nxt_cnt = BIT_FIRST;
					if (rw_ff) begin
						nxt_tx     = rd_data;
						nxt_rd_en  = 1'b1;
						nxt_sda_oe = load_oe; // R11
						nxt_state  = ST_TX;
					end else begin
						nxt_sda_oe = 1'b0;
						nxt_state  = ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (tx_last) begin
						nxt_sda_oe = 1'b0;
						nxt_ptr    = ptr_ff + PTR_ONE; // R18
						nxt_state  = ST_MACK;
					end else begin
						nxt_tx     = {tx_ff[BYTE_W-2:0], 1'b0};
						nxt_sda_oe = next_oe;
						nxt_cnt    = cnt_ff + CNT_ONE;
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					nxt_mack = ~sda_sync_ff; // R7
				end
				if (scl_fall) begin
					nxt_cnt = BIT_FIRST;
					if (mack_ff) begin
						nxt_tx     = rd_data;
						nxt_rd_en  = 1'b1;
						nxt_sda_oe = load_oe;
						nxt_state  = ST_TX;
					end else begin
						// end of read: line stays released for the STOP
						nxt_sda_oe = 1'b0; // R9
						nxt_state  = ST_WAIT; // R9
					end
				end
			end
			default: begin
				nxt_state = state_ff;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff   <= ST_IDLE;
			cnt_ff     <= BIT_FIRST;
			idx_ff     <= IDX_ADDR;
			rw_ff      <= 1'b0;
			access_ff  <= 1'b0;
			shift_ff   <= '0;
			tx_ff      <= '0;
			ptr_ff     <= '0;
			mack_ff    <= 1'b0;
			sda_oe_ff  <= 1'b0;
			wr_en_ff   <= 1'b0;
			rd_en_ff   <= 1'b0;
			wr_addr_ff <= '0;
			wr_data_ff <= '0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			idx_ff     <= nxt_idx;
			rw_ff      <= nxt_rw;
			access_ff  <= nxt_access;
			shift_ff   <= nxt_shift;
			tx_ff      <= nxt_tx;
			ptr_ff     <= nxt_ptr;
			mack_ff    <= nxt_mack;
			sda_oe_ff  <= nxt_sda_oe;
			wr_en_ff   <= nxt_wr_en;
			rd_en_ff   <= nxt_rd_en;
			wr_addr_ff <= nxt_wr_addr;
			wr_data_ff <= nxt_wr_data;
		end
	end

	rtc_twi_wdog #(
		.OSC_HZ      (OSC_HZ)
	) u_wdog (
		.osc_clk     (osc_clk),
		.reset       (reset),
		.access      (access_ff),
		.expire_tgl  (expire_tgl),
		.sec_tick    (sec_tick),
		.time_frozen (time_frozen)
	);

	// SCL is never driven; SDA only ever pulls low
	assign sda_out = 1'b0; // R11
	assign sda_oe  = sda_oe_ff; // R11
	assign rd_addr = ptr_ff;
	assign rd_en   = rd_en_ff;
	assign wr_addr = wr_addr_ff;
	assign wr_data = wr_data_ff;
	assign wr_en   = wr_en_ff;
	assign access  = access_ff;

endmodule

// >>> rtc_twi_checker.sv
// concurrent checks on the serial slave ports
`timescale 1ns/1ps
module rtc_twi_checker #(
	parameter int OSC_HZ = rtc_twi_pkg::DEF_OSC_HZ
) (
	input wire logic			clk,
	input wire logic			reset,
	input wire logic			osc_clk,
	input wire logic			scl_in,
	input wire logic			sda_in,
	input wire logic			sda_out,
	input wire logic			sda_oe,
	input wire logic [rtc_twi_pkg::PTR_W-1:0]	rd_addr,
	input wire logic			rd_en,
	input wire logic [rtc_twi_pkg::PTR_W-1:0]	wr_addr,
	input wire logic			wr_en,
	input wire logic			access,
	input wire logic			sec_tick,
	input wire logic			time_frozen
);
	import rtc_twi_pkg::*;
	// slack covers the two sync stages on each side of the crossing
	localparam int WMAX = 2 * OSC_HZ + 8;
	// wide enough for a full second count at the real oscillator rate
	logic [31:0] acc_cnt_ff;
	logic [31:0] nxt_acc_cnt;
	assign nxt_acc_cnt = access ? acc_cnt_ff + 32'h1 : 32'h0;
	always_ff @(posedge osc_clk) begin
		acc_cnt_ff <= reset ? 32'h0 : nxt_acc_cnt;
	end
	sequence s_start;
		scl_in && $past(scl_in) && $fell(sda_in);
	endsequence
	sequence s_stop;
		scl_in && $past(scl_in) && $rose(sda_in);
	endsequence
	property p_start;
		@(posedge clk) disable iff (reset) s_start |-> ##[1:8] !access;
	endproperty
	property p_stop;
		@(posedge clk) disable iff (reset) s_stop |-> ##[1:8] !access;
	endproperty
	property p_sda_stable;
		@(posedge clk) disable iff (reset)
			scl_in && $past(scl_in, 2) && $past(scl_in, 4) |-> $stable(sda_oe);
	endproperty
	property p_ack_hold;
		@(posedge clk) disable iff (reset) $rose(sda_oe) |-> sda_oe [*8];
	endproperty
	property p_oe_acc;
		@(posedge clk) disable iff (reset)
			sda_oe |-> !sda_out && (access || $past(access));
	endproperty
	property p_xfer_acc;
		@(posedge clk) disable iff (reset) (wr_en || rd_en) |-> access;
	endproperty
	property p_wr_ptr;
		@(posedge clk) disable iff (reset)
			wr_en |-> ##[0:1] rd_addr == wr_addr + 4'h1;
	endproperty
	property p_no_tick;
		@(posedge osc_clk) disable iff (reset) time_frozen |-> !sec_tick;
	endproperty
	property p_freeze;
		@(posedge osc_clk) disable iff (reset)
			$rose(access) |-> ##[1:4] time_frozen;
	endproperty
	property p_wmax;
		@(posedge osc_clk) disable iff (reset) acc_cnt_ff <= 32'(WMAX);
	endproperty
	// a repeated START drops access while SCL is still high; a hung master
	// holds SCL low, so only an expiry sees it low on two osc samples
	property p_wmin;
		@(posedge osc_clk) disable iff (reset)
			$fell(access) && !scl_in && !$past(scl_in) |->
				acc_cnt_ff >= 32'(OSC_HZ - 2);
	endproperty
	a_start: assert property (p_start) else $error("start kept access");
	a_stop: assert property (p_stop) else $error("stop kept access");
	a_sda_stable: assert property (p_sda_stable) else $error("sda moved");
	a_ack_hold: assert property (p_ack_hold) else $error("short low");
	a_oe_acc: assert property (p_oe_acc) else $error("drive idle");
	a_xfer_acc: assert property (p_xfer_acc) else $error("no access");
	a_wr_ptr: assert property (p_wr_ptr) else $error("ptr step");
	a_no_tick: assert property (p_no_tick) else $error("tick frozen");
	a_freeze: assert property (p_freeze) else $error("not frozen");
	a_wmax: assert property (p_wmax) else $error("watchdog late");
	a_wmin: assert property (p_wmin) else $error("watchdog early");
endmodule

bind rtc_twi_slave rtc_twi_checker #(.OSC_HZ(OSC_HZ)) i_chk (
	.clk, .reset, .osc_clk, .scl_in, .sda_in, .sda_out, .sda_oe, .rd_addr,
	.rd_en, .wr_addr, .wr_en, .access, .sec_tick, .time_frozen
);

// >>> rtc_twi_master_model.sv
// behavioural two-wire bus master on the slave's pins
`timescale 1ns/1ps
module rtc_twi_master_model #(
	parameter int HALF = 30
) (
	output logic		scl,
	output logic		sda_low,
	input wire logic	sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// also a repeated start: data is let go before the clock rises
	task automatic start();
		sda_low = 1'b0;
		#HALF scl = 1'b1;
		#HALF sda_low = 1'b1;
		#HALF scl = 1'b0;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#HALF scl = 1'b1;
		#HALF sda_low = 1'b0;
		#HALF;
	endtask
	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		#HALF scl = 1'b1;
		#HALF r = sda;
		scl = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack_n);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], ack_n);
		end
		bit_io(1'b1, ack_n);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic x;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, x);
	endtask
endmodule

// >>> rtc_i2c_slave_with_watchdog_tb_top.sv
// self-checking bench for the serial slave and its watchdog
`timescale 1ns/1ps
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("unexpected %0t: %h %h", $time, g, e); \
	end \
end
module rtc_i2c_slave_with_watchdog_tb_top;
	import rtc_twi_pkg::*;
	localparam int OSC = 64;
	localparam int CP = 5;
	localparam int OP = 32;
	logic			clk;
	logic			reset;
	logic			osc_clk;
	logic			scl;
	logic			m_low;
	logic			sda;
	logic			sda_out;
	logic			sda_oe;
	logic [PTR_W-1:0]	rd_addr;
	logic [BYTE_W-1:0]	rd_data;
	logic			rd_en;
	logic [PTR_W-1:0]	wr_addr;
	logic [BYTE_W-1:0]	wr_data;
	logic			wr_en;
	logic			access;
	logic			sec_tick;
	logic			time_frozen;
	logic [BYTE_W-1:0]	regs [16];
	int			error_cnt;
	int			samples_checked;
	// pull-up: the line is high unless someone pulls it low
	assign sda = !(sda_oe === 1'b1 || m_low === 1'b1);
	assign rd_data = regs[rd_addr];
	rtc_twi_slave #(.OSC_HZ(OSC)) i_dut (
		.clk, .reset, .osc_clk, .scl_in(scl), .sda_in(sda), .sda_out,
		.sda_oe, .rd_addr, .rd_data, .rd_en, .wr_addr, .wr_data, .wr_en,
		.access, .sec_tick, .time_frozen
	);
	rtc_twi_master_model i_mst (.scl, .sda_low(m_low), .sda);
	initial begin
		clk = 1'b0;
		forever #(CP / 2.0) clk = !clk;
	end
	initial begin
		osc_clk = 1'b0;
		#1.3;
		forever #(OP / 2) osc_clk = !osc_clk;
	end
	always @(posedge clk) begin
		if (wr_en === 1'b1) begin
			regs[wr_addr] <= wr_data;
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// word FF: upper bits dropped, second byte wraps to register 0
	task automatic t_write();
		logic a;
		@(posedge clk);
		#1;
		i_mst.start();
		i_mst.wbyte(ADDR_WR, a);
		`CHK(a, 1'b0)
		i_mst.wbyte(8'hFF, a);
		`CHK(a, 1'b0)
		i_mst.wbyte(8'h3C, a);
		`CHK(a, 1'b0)
		i_mst.wbyte(8'h7E, a);
		`CHK(time_frozen, 1'b1)
		i_mst.stop();
		repeat (4) @(posedge osc_clk);
		`CHK(time_frozen, 1'b0)
		`CHK(regs[15], 8'h3C)
		`CHK(regs[0], 8'h7E)
		$display("write test done");
	endtask
	task automatic t_read();
		logic a;
		logic [7:0] d;
		@(posedge clk);
		#1;
		i_mst.start();
		i_mst.wbyte(ADDR_WR, a);
		i_mst.wbyte(8'h0F, a);
		i_mst.start();
		i_mst.wbyte(ADDR_RD, a);
		`CHK(a, 1'b0)
		i_mst.rbyte(1'b0, d);
		`CHK(d, 8'h3C)
		i_mst.rbyte(1'b1, d);
		`CHK(d, 8'h7E)
		#(8 * CP);
		`CHK(sda_oe, 1'b0)
		i_mst.stop();
		$display("read test done");
	endtask
	task automatic t_bad();
		logic a;
		@(posedge clk);
		#1;
		i_mst.start();
		i_mst.wbyte(8'hA4, a);
		`CHK(a, 1'b1)
		`CHK(access, 1'b0)
		i_mst.wbyte(8'h00, a);
		`CHK(a, 1'b1)
		i_mst.stop();
		$display("address test done");
	endtask
	// clock held low after the address: only the watchdog can end it
	task automatic t_wdog();
		logic a;
		int ticks;
		int cyc;
		ticks = 0;
		cyc = 0;
		@(posedge osc_clk);
		fork
			repeat (6 * OSC) begin
				@(posedge osc_clk);
				#1;
				if (sec_tick === 1'b1) begin
					ticks++;
				end
			end
			begin
				@(posedge clk);
				#1;
				i_mst.start();
				i_mst.wbyte(ADDR_WR, a);
				while (access === 1'b1 && cyc < 2000) begin
					#CP;
					cyc++;
				end
				`CHK(access, 1'b0)
				`CHK(cyc >= OSC * OP / CP - 20, 1'b1)
				`CHK(cyc <= 2 * OSC * OP / CP + 40, 1'b1)
				`CHK(sda_oe, 1'b0)
				i_mst.wbyte(ADDR_WR, a);
				`CHK(a, 1'b1)
				i_mst.stop();
			end
		join
		`CHK(ticks, 5)
		$display("watchdog test done");
	endtask
	initial begin
		#60000;
		error_cnt++;
		finish_test();
	end
	initial begin
		error_cnt = 0;
		samples_checked = 0;
		reset = 1'b1;
		for (int i = 0; i < 16; i++) begin
			regs[i] = 8'h00;
		end
		// osc side syncs reset, so it must see several of its own edges
		repeat (4) @(posedge osc_clk);
		@(posedge clk);
		#1;
		reset = 1'b0;
		repeat (4) @(posedge clk);
		t_write();
		t_read();
		t_bad();
		t_wdog();
		finish_test();
	end
endmodule
